/* fcsm_pkg.sv */
// fcsm_pkg: constants, types and carriers of the flash command host.
// assumes a 25 MHz sys_clk and an async parallel nor flash on the pins.
//
// Summary of operation
// - id mode left only by reset write
// - sector erase is six ordered writes
// - next sector load within 50 us window
// - wait 10 ms after resume past 1024
// - program is four writes then self-timed
`default_nettype none

package fcsm_pkg;
    // -------------------------------------------------------------
    // sizes and timing
    // -------------------------------------------------------------
    localparam int ADDR_W = 21; // flash word address
    localparam int DQ_W = 16; // flash data bus
    localparam int CLK_MHZ = 25; // sys_clk rate
    localparam int TMR_W = 18; // wide enough for the resume gap
    localparam logic [1:0] STB_CYC = 2'h1; // strobe low is this plus one
    localparam int WIN_US = 50; // sector load window
    localparam int WIN_CYC = WIN_US * CLK_MHZ; // longest, rounds down
    localparam int GAP_MS = 10; // spacing after many resumes
    localparam int GAP_CYC_DEF = GAP_MS * 1000 * CLK_MHZ;
    localparam logic [10:0] SUSP_LIM = 11'h400; // suspend/resume pairs
    // -------------------------------------------------------------
    // flash command codes
    // -------------------------------------------------------------
    localparam logic [DQ_W-1:0] CMD_ESETUP = 16'h0080;
    localparam logic [DQ_W-1:0] CMD_SERASE = 16'h0030;
    localparam logic [DQ_W-1:0] CMD_SUSP = 16'h00B0;
    localparam logic [DQ_W-1:0] CMD_RESUME = 16'h0030;
    localparam logic [DQ_W-1:0] CMD_RESET = 16'h00F0;
    localparam int POLL_BIT = 7; // polling status bit
    localparam int TOUT_BIT = 5; // timeout-exceeded status bit
    // -------------------------------------------------------------
    // software register indices
    // -------------------------------------------------------------
    localparam logic [2:0] REG_CMD = 3'h0;
    localparam logic [2:0] REG_ADDR = 3'h1;
    localparam logic [2:0] REG_DATA = 3'h2;
    localparam logic [2:0] REG_STAT = 3'h3;
    localparam logic [2:0] REG_RDATA = 3'h4;
    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [3:0] {OP_NONE, OP_RESET, OP_PROG, OP_ERASE, OP_ADD,
        OP_SUSP, OP_RESUME, OP_IDQ, OP_READ} fcsm_op_e;
    typedef enum logic [2:0] {S_IDLE, S_SEQ, S_SEQW, S_WIN, S_POLL, S_POLLW,
        S_FIN, S_FINW} fcsm_st_e;
    typedef enum logic [1:0] {BP_IDLE, BP_SET, BP_STB, BP_HOLD} fcsm_bph_e;
    // one flash bus cycle request
    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dq;
    } fcsm_req_s;
    // flash pin outputs
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dq;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
    } fcsm_pin_s;
    // bus cycle engine state
    typedef struct packed {
        fcsm_bph_e ph;
        logic [1:0] cnt;
        logic wr;
        fcsm_pin_s pin;
        logic done;
        logic [DQ_W-1:0] rd;
    } fcsm_bus_s;
    localparam fcsm_bus_s BUS_RST = '{ph: BP_IDLE, cnt: 2'h0, wr: 1'b0,
        pin: '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1,
        oe_n: 1'b1}, done: 1'b0, rd: '0};
endpackage : fcsm_pkg

`default_nettype wire

/* fcsm_tmr.sv */
// fcsm_tmr: down counter, busy while a loaded count runs out.
// assumes load is a one-cycle pulse from the command sequencer.
`default_nettype none

module fcsm_tmr
    import fcsm_pkg::*;
#(
    parameter int W = TMR_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // control
    input wire logic load,
    input wire logic [W-1:0] val,
    // status
    output logic busy
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
    } fcsm_tmr_s;

    fcsm_tmr_s r, n; // registered state and its next value

    // count down, reload wins over the running count
    always_comb begin
        n = r;
        if (load) begin
            n.cnt = val;
        end else if (r.cnt != '0) begin
            n.cnt = r.cnt - 1'b1;
        end
        n.busy = (n.cnt != '0);
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign busy = r.busy;
endmodule : fcsm_tmr

`default_nettype wire

/* fcsm_bus.sv */
// fcsm_bus: runs one read or write cycle on the flash pins.
// assumes requests come only while idle; done pulses once per cycle.
`default_nettype none

module fcsm_bus
    import fcsm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // request side
    input wire logic req,
    input wire fcsm_req_s rq,
    output logic done,
    output logic [DQ_W-1:0] rd,
    // flash pins
    output fcsm_pin_s pin,
    input wire logic [DQ_W-1:0] dq_i
);
    fcsm_bus_s r, n; // registered state and its next value

    // ce falls a cycle before we/oe, so address is settled on the
    // later falling edge and data stays until strobes rise together
    always_comb begin
        n = r;
        n.done = 1'b0;
        case (r.ph)
            BP_IDLE: begin
                if (req) begin
                    n.wr = rq.wr;
                    n.pin.addr = rq.addr;
                    n.pin.dq = rq.dq;
                    n.pin.dq_oe = rq.wr;
                    n.pin.ce_n = 1'b0;
                    n.ph = BP_SET;
                end
            end
            BP_SET: begin
                n.pin.we_n = !r.wr;
                n.pin.oe_n = r.wr;
                n.cnt = STB_CYC;
                n.ph = BP_STB;
            end
            BP_STB: begin
                if (r.cnt != 2'h0) begin
                    n.cnt = r.cnt - 2'h1;
                end else begin
                    // sample read data while oe is still low
                    if (!r.wr) begin
                        n.rd = dq_i;
                    end
                    n.pin.we_n = 1'b1;
                    n.pin.oe_n = 1'b1;
                    n.ph = BP_HOLD;
                end
            end
            BP_HOLD: begin
                n.pin.ce_n = 1'b1;
                n.pin.dq_oe = 1'b0;
                n.done = 1'b1;
                n.ph = BP_IDLE;
            end
            default: n = BUS_RST;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= BUS_RST;
        end else begin
            r <= n;
        end
    end

    assign pin = r.pin;
    assign done = r.done;
    assign rd = r.rd;
endmodule : fcsm_bus

`default_nettype wire

/* fcsm_host.sv */
// fcsm_host: flash command host; turns software orders into flash
// command sequences and polls the flash status until done.
// assumes one flash on the pins and a single-cycle software port.
//
// Decided for this implementation: the address map and strobed register access.
`default_nettype none

module fcsm_host
    import fcsm_pkg::*;
#(
    parameter int GAP_CYC = GAP_CYC_DEF, // resume spacing in cycles
    parameter logic [ADDR_W-1:0] UNLK_A1 = 21'h000555, // unlock address 1
    parameter logic [ADDR_W-1:0] UNLK_A2 = 21'h0002AA, // unlock address 2
    parameter logic [DQ_W-1:0] UNLK_D1 = 16'h00AA, // unlock data 1
    parameter logic [DQ_W-1:0] UNLK_D2 = 16'h0055, // unlock data 2
    parameter logic [DQ_W-1:0] PGM_CODE = 16'h00A0, // program set-up
    parameter logic [DQ_W-1:0] IDQ_CODE = 16'h0090 // id query entry
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // software port
    input wire logic [2:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    // flash pins
    output fcsm_pin_s fl_pin,
    input wire logic [DQ_W-1:0] fl_dq_i
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        fcsm_st_e st; // sequencer state
        fcsm_op_e op; // operation in flight
        logic [2:0] step; // write cycle within the sequence
        logic [ADDR_W-1:0] tgt; // software target address
        logic [DQ_W-1:0] dat; // software program data
        logic [ADDR_W-1:0] ers; // sector under erase
        logic id_mode; // flash sits in id query mode
        logic susp; // erase is suspended
        logic pend_susp; // suspend asked during erase polling
        logic fail; // operation reported timeout twice
        logic done; // last order finished
        logic tout; // timeout bit seen once
        logic [10:0] pairs; // suspend/resume pairs so far
        logic req; // bus cycle request pulse
        fcsm_req_s rq; // bus cycle contents
        logic [DQ_W-1:0] last; // last valid read word
        logic [31:0] rdata; // software read data
        logic win_ld; // start sector load window
        logic gap_ld; // start resume spacing
        logic [10:0] win_age; // cycles spent in the load window
    } fcsm_top_s;

    fcsm_top_s r, n; // registered state and its next value
    logic bus_done; // bus cycle finished
    logic [DQ_W-1:0] bus_rd; // word read by the bus cycle
    logic win_busy; // sector load window still open
    logic gap_busy; // resume spacing still running
    fcsm_op_e cmd; // order written by software
    logic cmd_wr; // software writes the order register
    logic ok_idle; // order allowed from idle
    logic [ADDR_W-1:0] poll_a; // address to poll
    logic expect_b; // polling bit value that means done
    logic [5:0] stat; // status word

    // -------------------------------------------------------------
    // sequence table
    // -------------------------------------------------------------
    // index of the last write cycle of each operation
    function automatic logic [2:0] seq_last(input fcsm_op_e op);
        case (op)
            OP_PROG: seq_last = 3'h3;
            OP_ERASE: seq_last = 3'h5;
            OP_IDQ: seq_last = 3'h2;
            default: seq_last = 3'h0;
        endcase
    endfunction : seq_last

    // address and data of each write cycle
    function automatic fcsm_req_s seq_word(input fcsm_op_e op,
            input logic [2:0] st, input logic [ADDR_W-1:0] tgt,
            input logic [DQ_W-1:0] dat, input logic [ADDR_W-1:0] ers);
        fcsm_req_s w;
        w = '{wr: 1'b1, addr: UNLK_A1, dq: UNLK_D1};
        case (op)
            OP_RESET: w.dq = CMD_RESET;
            OP_ADD: w = '{wr: 1'b1, addr: tgt, dq: CMD_SERASE};
            OP_SUSP: w = '{wr: 1'b1, addr: ers, dq: CMD_SUSP};
            OP_RESUME: w = '{wr: 1'b1, addr: ers, dq: CMD_RESUME};
            default: begin
                // unlock, unlock, set-up, then erase repeats the unlocks
                case (st)
                    3'h1, 3'h4: w = '{wr: 1'b1, addr: UNLK_A2, dq: UNLK_D2};
                    3'h2: begin
                        w.dq = (op == OP_PROG) ? PGM_CODE :
                            (op == OP_IDQ) ? IDQ_CODE : CMD_ESETUP;
                    end
                    3'h3: begin
                        if (op == OP_PROG) begin
                            w = '{wr: 1'b1, addr: tgt, dq: dat};
                        end
                    end
                    3'h5: w = '{wr: 1'b1, addr: tgt, dq: CMD_SERASE};
                    default: w.dq = UNLK_D1;
                endcase
            end
        endcase
        seq_word = w;
    endfunction : seq_word

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    fcsm_bus u_bus (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .req(r.req),
        .rq(r.rq),
        .done(bus_done),
        .rd(bus_rd),
        .pin(fl_pin),
        .dq_i(fl_dq_i)
    );

    fcsm_tmr #(.W(TMR_W)) u_win (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(r.win_ld),
        .val(TMR_W'(WIN_CYC)),
        .busy(win_busy)
    );

    fcsm_tmr #(.W(TMR_W)) u_gap (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(r.gap_ld),
        .val(TMR_W'(GAP_CYC)),
        .busy(gap_busy)
    );

    // -------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------
    // decode, poll target and status
    always_comb begin
        cmd = fcsm_op_e'(sw_wdata[3:0]);
        cmd_wr = sw_wr && (sw_addr == REG_CMD);
        poll_a = (r.op == OP_PROG || r.op == OP_READ) ? r.tgt : r.ers;
        expect_b = (r.op == OP_PROG) ? r.dat[POLL_BIT] : 1'b1;
        stat = {r.done, r.id_mode, r.fail, r.susp, r.st == S_WIN,
            r.st != S_IDLE};
        case (cmd)
            OP_RESET, OP_IDQ, OP_READ: ok_idle = 1'b1;
            OP_PROG: ok_idle = !r.id_mode;
            OP_ERASE: ok_idle = !r.id_mode && !r.susp;
            OP_RESUME: ok_idle = r.susp && !gap_busy;
            default: ok_idle = 1'b0;
        endcase
    end

    // next state: software access, then the sequencer
    always_comb begin
        n = r;
        n.req = 1'b0;
        n.win_ld = 1'b0;
        n.gap_ld = 1'b0;
        n.rdata = '0;
        n.win_age = (r.st == S_WIN) ? r.win_age + 11'h001 : 11'h000;
        // target registers only move while no sequence uses them
        if (sw_wr && (r.st == S_IDLE || r.st == S_WIN)) begin
            if (sw_addr == REG_ADDR) begin
                n.tgt = sw_wdata[ADDR_W-1:0];
            end
            if (sw_addr == REG_DATA) begin
                n.dat = sw_wdata[DQ_W-1:0];
            end
        end
        // read data only in the cycle after the strobe
        if (sw_rd) begin
            case (sw_addr)
                REG_ADDR: n.rdata = 32'(r.tgt);
                REG_DATA: n.rdata = 32'(r.dat);
                REG_STAT: n.rdata = 32'(stat);
                REG_RDATA: n.rdata = 32'(r.last);
                default: n.rdata = '0;
            endcase
        end
        // suspend asked while erase polling waits for a cycle boundary
        if (cmd_wr && cmd == OP_SUSP && r.op == OP_ERASE && !gap_busy &&
                (r.st == S_POLL || r.st == S_POLLW)) begin
            n.pend_susp = 1'b1;
        end
        case (r.st)
            S_IDLE: begin
                if (cmd_wr && ok_idle) begin
                    n.op = cmd;
                    n.step = 3'h0;
                    n.done = 1'b0;
                    n.tout = 1'b0;
                    n.st = (cmd == OP_READ) ? S_FIN : S_SEQ;
                    if (cmd == OP_ERASE) begin
                        n.ers = r.tgt;
                    end
                end
            end
            S_SEQ: begin
                n.req = 1'b1;
                n.rq = seq_word(r.op, r.step, r.tgt, r.dat, r.ers);
                n.st = S_SEQW;
            end
            S_SEQW: begin
                if (bus_done) begin
                    if (r.step != seq_last(r.op)) begin
                        n.step = r.step + 3'h1;
                        n.st = S_SEQ;
                    end else begin
                        case (r.op)
                            OP_RESET: begin
                                n.id_mode = 1'b0;
                                n.fail = 1'b0;
                                n.done = 1'b1;
                                n.st = S_IDLE;
                            end
                            OP_IDQ: begin
                                n.id_mode = 1'b1;
                                n.done = 1'b1;
                                n.st = S_IDLE;
                            end
                            OP_ERASE, OP_ADD: begin
                                n.win_ld = 1'b1;
                                n.st = S_WIN;
                            end
                            OP_RESUME: begin
                                n.op = OP_ERASE;
                                n.susp = 1'b0;
                                if (r.pairs != SUSP_LIM) begin
                                    n.pairs = r.pairs + 11'h001;
                                end
                                // spacing once the pair count is used up
                                n.gap_ld = (n.pairs == SUSP_LIM);
                                n.st = S_POLL;
                            end
                            default: n.st = S_POLL; // program, suspend
                        endcase
                    end
                end
            end
            S_WIN: begin
                // only more sectors, suspend or reset go in here
                if (cmd_wr && (cmd == OP_ADD || cmd == OP_SUSP ||
                        cmd == OP_RESET)) begin
                    n.op = cmd;
                    n.step = 3'h0;
                    n.st = S_SEQ;
                end else if (!win_busy && !r.win_ld) begin
                    n.op = OP_ERASE;
                    n.st = S_POLL;
                end
            end
            S_POLL: begin
                n.req = 1'b1;
                n.rq = '{wr: 1'b0, addr: poll_a, dq: '0};
                n.st = S_POLLW;
            end
            S_POLLW: begin
                if (bus_done) begin
                    if (bus_rd[POLL_BIT] == expect_b) begin
                        n.st = S_FIN;
                    end else if (r.pend_susp) begin
                        n.pend_susp = 1'b0;
                        n.op = OP_SUSP;
                        n.step = 3'h0;
                        n.st = S_SEQ;
                    end else if (bus_rd[TOUT_BIT] && r.tout) begin
                        n.fail = 1'b1; // still not done after timeout
                        n.done = 1'b1;
                        n.st = S_IDLE;
                    end else begin
                        n.tout = r.tout | bus_rd[TOUT_BIT];
                        n.st = S_POLL;
                    end
                end
            end
            S_FIN: begin
                // one more read: other data bits may lag the polling bit
                n.req = 1'b1;
                n.rq = '{wr: 1'b0, addr: poll_a, dq: '0};
                n.st = S_FINW;
            end
            S_FINW: begin
                if (bus_done) begin
                    n.last = bus_rd;
                    n.done = 1'b1;
                    n.pend_susp = 1'b0;
                    if (r.op == OP_SUSP) begin
                        n.susp = 1'b1;
                    end
                    n.st = S_IDLE;
                end
            end
            default: n.st = S_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sw_rdata = r.rdata;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_id_exit_reset: assert property (
        $fell(r.id_mode) |-> $past(r.op) == OP_RESET)
        else $error("id mode left without a reset write");
    a_erase_six_cycles: assert property (
        (r.st == S_SEQW && bus_done && r.op == OP_ERASE) |->
        (r.step == 3'h5) == (n.st == S_WIN))
        else $error("erase window opened at wrong cycle");
    a_window_bound: assert property (
        int'(r.win_age) <= WIN_CYC + 10)
        else $error("sector load window held too long");
    a_resume_spacing: assert property (
        (r.st == S_IDLE && cmd_wr && cmd == OP_RESUME && gap_busy) |=>
        r.st == S_IDLE)
        else $error("resume issued inside spacing time");
    a_prog_four_writes: assert property (
        (r.st == S_POLL && r.op == OP_PROG && $past(r.st) == S_SEQW) |->
        $past(r.step) == 3'h3 && r.rq.addr == r.tgt && r.rq.dq == r.dat)
        else $error("program polled before its fourth write");
    a_unlock_first: assert property (
        (r.req && r.rq.wr && r.step == 3'h0 &&
        (r.op == OP_PROG || r.op == OP_ERASE)) |->
        r.rq.addr == UNLK_A1 && r.rq.dq == UNLK_D1)
        else $error("sequence does not open with unlock");
    a_data_after_poll: assert property (
        (r.last != $past(r.last)) |-> $past(r.st) == S_FINW)
        else $error("data taken outside the confirming read");

    c_program: cover property (r.op == OP_PROG && r.st == S_FINW ##1
        r.st == S_IDLE);
    c_window_add: cover property (r.st == S_WIN ##[1:50] r.op == OP_ADD);
    c_suspend: cover property ($rose(r.susp));
    c_resume: cover property ($fell(r.susp));
endmodule : fcsm_host

`default_nettype wire

/* fcsm_flash_model.sv */
// fcsm_flash_model: small behavioural nor flash on the host pins.
// assumes pins are sampled on sys_clk and strobes last several clocks.
`default_nettype none
module fcsm_flash_model
    import fcsm_pkg::*;
(
    // clock and pins
    input wire logic sys_clk,
    input wire fcsm_pin_s pin,
    output logic [DQ_W-1:0] dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DQ_W-1:0] mem [16]; // folded array
    logic [DQ_W-1:0] pd; // datum being programmed
    logic [3:0] pa; // latched target
    logic [3:0] ea; // sector under erase, kept apart from program target
    logic tg = 1'b0; // toggle status while busy
    logic [2:0] seq = 3'h0; // unlock progress
    logic [1:0] md = 2'h0; // 0 read, 1 program, 2 erase, 3 suspended
    logic [1:0] left; // busy status reads left
    logic sus = 1'b0; // erase suspended underneath
    logic we_q = 1'b1;
    logic oe_q = 1'b1;
    logic [7:0] c;
    assign c = pin.dq[7:0];
    initial for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
    // writes act on strobe release; address held since the fall
    always @(posedge sys_clk) begin
        we_q <= pin.we_n;
        oe_q <= pin.oe_n;
        if (pin.we_n && !we_q && md != 2'h1) begin
            if (c == 8'hF0) seq <= 3'h0;
            else if (c == 8'hB0 && md == 2'h2) begin
                md <= 2'h3;
                sus <= 1'b1;
            end else if (c == 8'h30 && md == 2'h3 && seq == 3'h0) begin
                md <= 2'h2;
                sus <= 1'b0;
            end else begin
                seq <= 3'h0;
                case (seq)
                3'h0, 3'h3: if (c == 8'hAA) seq <= seq + 3'h1;
                3'h1, 3'h4: if (c == 8'h55) seq <= seq + 3'h1;
                3'h2: seq <= (c == 8'hA0) ? 3'h6 : (c == 8'h80) ? 3'h3 : 3'h0;
                3'h5: if (c == 8'h30) begin
                    md <= 2'h2;
                    ea <= pin.addr[3:0];
                    left <= 2'h3;
                end
                3'h6: begin
                    md <= 2'h1;
                    pa <= pin.addr[3:0];
                    pd <= pin.dq;
                    left <= 2'h3;
                end
                default: seq <= 3'h0;
                endcase
            end
        end
        if (!pin.oe_n && oe_q) begin
            if (md != 2'h0 && md != 2'h3 && left != 2'h0) begin
                dq <= ((md == 2'h1) ? (~pd & 16'h0080) : 16'h0000) |
                    {9'h000, tg, 6'h00};
                tg <= ~tg;
                left <= left - 2'h1;
            end else if (md == 2'h1) begin
                mem[pa] <= mem[pa] & pd;
                dq <= mem[pa] & pd;
                md <= {sus, sus};
            end else if (md == 2'h2) begin
                mem[ea] <= 16'hFFFF;
                dq <= 16'hFFFF;
                md <= 2'h0;
            end else if (md == 2'h3 && pin.addr[3:0] == ea) dq <= 16'hFFFF;
            else dq <= mem[pin.addr[3:0]];
        end else if (pin.oe_n) dq <= ~dq; // released bus
    end
endmodule : fcsm_flash_model
`default_nettype wire

/* flash_command_state_machine_bench.sv */
// flash_command_state_machine_bench: fcsm_host against the flash model.
// assumes fcsm_flash_model; software orders checked against results.
`default_nettype none
module flash_command_state_machine_bench;
    import fcsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] sw_addr = 3'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    logic [31:0] v;
    fcsm_pin_s fl_pin;
    logic [DQ_W-1:0] fl_dq_i;
    int fail_count = 0;
    int checked = 0;
    always #20 sys_clk = ~sys_clk;
    fcsm_host #(.GAP_CYC(20)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .fl_pin(fl_pin), .fl_dq_i(fl_dq_i));
    fcsm_flash_model u_flash (.sys_clk(sys_clk), .pin(fl_pin), .dq(fl_dq_i));
    task automatic summarize();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge sys_clk);
        sw_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [2:0] a);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge sys_clk);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
        @(posedge sys_clk);
    endtask : rd
    task automatic chk(input logic [2:0] a, input logic [31:0] e);
        rd(a);
        checked++;
        if (v !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, v, e);
        end
    endtask : chk
    // bounded poll of one status bit
    task automatic wt(input int b);
        for (int i = 0; i < 4000; i++) begin
            rd(REG_STAT);
            if (v[b] === 1'b1) return;
        end
        fail_count++;
        summarize();
    endtask : wt
    task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
        wr(REG_ADDR, a);
        wr(REG_DATA, d);
        wr(REG_CMD, c);
        if (c != 32'h3) wt(5);
    endtask : op
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        chk(3'h7, 32'h0); // unmapped index
        op(32'h3, 32'h1234, 32'h2);
        chk(REG_RDATA, 32'h1234);
        op(32'h3, 32'h5634, 32'h2);
        chk(REG_RDATA, 32'h1234);
        op(32'h3, 32'h0, 32'h3);
        wt(1);
        wr(REG_CMD, 32'h4);
        wt(1);
        wr(REG_CMD, 32'h5);
        wt(2);
        op(32'h5, 32'hA5, 32'h2);
        chk(REG_RDATA, 32'hA5);
        wr(REG_CMD, 32'h6);
        wt(5);
        op(32'h3, 32'h0, 32'h8);
        chk(REG_RDATA, 32'hFFFF);
        op(32'h5, 32'h0, 32'h8);
        chk(REG_RDATA, 32'hA5);
        wr(REG_CMD, 32'h7);
        wt(5);
        chk(REG_STAT, 32'h30);
        wr(REG_CMD, 32'h2);
        chk(REG_STAT, 32'h30);
        wr(REG_CMD, 32'h1);
        wt(5);
        chk(REG_STAT, 32'h20);
        summarize();
    end
endmodule : flash_command_state_machine_bench
`default_nettype wire
